// ---- hdl/irq_sel_defs.svh ----
`ifndef IRQ_SEL_DEFS_SVH
`define IRQ_SEL_DEFS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define SEL_ADDR_W 8
`define SEL_OFFSET 8'ha8
`define SEL_RESET 32'h0000_0000
`define SEL_LINES 25
`define SEL_FIRST_LINE 34
`define SEL_BIT_LO 0
`define SEL_BIT_HI 24

`endif

// ---- hdl/irq_sel_pkg.sv ----
package irq_sel_pkg;
    typedef logic [31:0] word_type;
endpackage : irq_sel_pkg

// ---- hdl/pin_pair_mux.sv ----
`timescale 1ns/1ps
module pin_pair_mux (
    input wire logic odd_pin,
    input wire logic even_pin,
    input wire logic sel,
    output logic y
);
    // Select 0 takes the odd pin of the pair
    assign y = sel ? even_pin : odd_pin;
endmodule : pin_pair_mux

// ---- hdl/extra_irq_select.sv ----
// Contract
// - Select bit n routes extra line 34+n from pin 2n+1 when 0 and from pin 2n when 1.
// - Bit 24 picks line 58 from pin 49 when 0 and from pin 48 when 1.
// - Bit 0 picks line 34 from pin 1 when 0 and from pin 0 when 1.
// - All 25 select bits reset to 0, selecting the odd pin of each pair.
// - The select register sits at offset 0xa8, is read/write and reads back bits 24:0 of what was written; bits 31:25 read as zero.
`timescale 1ns/1ps
`include "irq_sel_defs.svh"
module extra_irq_select
    import irq_sel_pkg::*;
#(
    parameter int LINES = `SEL_LINES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [`SEL_ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [2*LINES-1:0] gpio_in,
    output logic [LINES-1:0] extra_irq
);
    initial begin
        if (LINES < 1 || LINES > 32) begin
            $error("LINES must be 1..32");
        end
    end

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rst_s1_q;
    logic rst_n_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Three stages; a change counts once stages two and three agree
    logic [2*LINES-1:0] s1_q;
    logic [2*LINES-1:0] s2_q;
    logic [2*LINES-1:0] s3_q;
    logic [2*LINES-1:0] pin_q;
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            pin_q <= '0;
        end else if (clk_en) begin
            s1_q <= gpio_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
        end
    end

    // ----------------------------------------
    // Select register
    // ----------------------------------------
    logic [LINES-1:0] sel_q;
    logic hit;
    assign hit = (addr == `SEL_OFFSET);
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sel_q <= LINES'(`SEL_RESET);
        end else if (clk_en && wr && hit) begin
            sel_q <= wdata[LINES-1:0];
        end
    end

    // Upper bits read as zero; unmapped offsets read zero
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata <= '0;
        end else if (clk_en) begin
            rdata <= (rd && hit) ? 32'(sel_q) : 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // Per-line source muxes
    // ----------------------------------------
    logic [LINES-1:0] mux_y;
    genvar n;
    generate
        for (n = 0; n < LINES; n++) begin : g_line
            pin_pair_mux u_mux (
                .odd_pin(pin_q[2*n+1]),
                .even_pin(pin_q[2*n]),
                .sel(sel_q[n]),
                .y(mux_y[n])
            );
        end
    endgenerate

    // Registered so every output comes from a flip-flop
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            extra_irq <= '0;
        end else if (clk_en) begin
            extra_irq <= mux_y;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_q);

    line_map_a: assert property (clk_en |=> extra_irq == $past(mux_y))
        else $error("line output mismatch");
    first_line_a: assert property (clk_en |=> extra_irq[0] ==
        $past(sel_q[0] ? pin_q[0] : pin_q[1]))
        else $error("line 34 source wrong");
    last_line_a: assert property (clk_en |=> extra_irq[LINES-1] ==
        $past(sel_q[LINES-1] ? pin_q[2*LINES-2] : pin_q[2*LINES-1]))
        else $error("last line source wrong");
    write_takes_a: assert property (clk_en && wr && hit |=>
        sel_q == $past(wdata[LINES-1:0]))
        else $error("select write lost");
    readback_a: assert property (clk_en && rd && hit |=>
        rdata == 32'($past(sel_q)))
        else $error("readback wrong");
    upper_zero_a: assert property (rdata[31:LINES] == '0)
        else $error("upper bits not zero");
    hold_sel_a: assert property (!(wr && hit && clk_en) |=> $stable(sel_q))
        else $error("select changed without write");
    freeze_out_a: assert property (!clk_en |=> $stable(extra_irq))
        else $error("output moved while frozen");
    reset_zero_a: assert property (@(posedge clk) $rose(rst_n_q) |-> sel_q == '0)
        else $error("select not reset");

    write_c: cover property (clk_en && wr && hit);
    read_c: cover property (clk_en && rd && hit ##1 rdata != '0);
    swap_c: cover property ($changed(sel_q[0]) ##1 $changed(extra_irq[0]));
    freeze_c: cover property (!clk_en && wr && hit);
endmodule : extra_irq_select

// ---- bench/gpio_pins.sv ----
`timescale 1ns/1ps
module gpio_pins (
    input wire logic [49:0] level,
    output logic [49:0] gpio_in
);
    // Pads settle after the edge, never on it
    assign #1 gpio_in = level;
endmodule : gpio_pins

// ---- bench/tb_extra_irq_select.sv ----
`timescale 1ns/1ps
module tb_extra_irq_select;
    import irq_sel_pkg::*;
    logic clk, rstn, wr, rd, clk_en;
    logic [7:0] addr;
    word_type wdata, rdata;
    logic [49:0] level, gpio_in;
    logic [24:0] extra_irq;
    int err_total, compares, cyc;
    word_type sv[4] = '{32'h0000_0001, 32'h0100_0000, 32'h01ff_ffff, 32'h0155_5555};
    logic [49:0] pv[3] = '{50'h2_aaaa_aaaa_aaaa, 50'h1_5555_5555_5555, 50'h3_0000_ffff_0f0f};
    extra_irq_select dut (.clk(clk), .rstn(rstn), .clk_en(clk_en), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .gpio_in(gpio_in), .extra_irq(extra_irq));
    gpio_pins pins (.level(level), .gpio_in(gpio_in));
    // ----------------
    // Clock and tasks
    // ----------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic chk(string what, logic [31:0] e, logic [31:0] s);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask : chk
    task automatic wr_reg(logic [7:0] a, word_type d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg
    task automatic rd_chk(logic [7:0] a, word_type e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rdata", e, rdata);
        @(posedge clk);
    endtask : rd_chk
    // Pin path passes a filter, so allow it to settle
    task automatic irq_chk(logic [49:0] p, word_type s);
        logic [31:0] e;
        e = '0;
        level <= p;
        repeat (8) @(posedge clk);
        #1;
        for (int n = 0; n < 25; n++) e[n] = s[n] ? p[2*n] : p[2*n+1];
        chk("extra_irq", e, {7'h00, extra_irq});
    endtask : irq_chk
    task automatic tally_and_finish();
        $display("mismatches %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        rstn = 1'b0;
        {wr, rd, addr, wdata, level} = '0;
        clk_en = 1'b1;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(8'ha8, 32'h0);
        irq_chk(pv[0], 32'h0);
        foreach (sv[i]) begin
            wr_reg(8'ha8, sv[i]);
            rd_chk(8'ha8, sv[i]);
            foreach (pv[j]) irq_chk(pv[j], sv[i]);
        end
        wr_reg(8'h00, 32'h0);
        rd_chk(8'ha4, 32'h0);
        rd_chk(8'ha8, sv[3]);
        // Frozen block must ignore a write
        clk_en <= 1'b0;
        wr_reg(8'ha8, 32'h0);
        clk_en <= 1'b1;
        rd_chk(8'ha8, sv[3]);
        // Second reset in mid-run clears the selects again
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(8'ha8, 32'h0);
        irq_chk(pv[1], 32'h0);
        tally_and_finish();
    end
endmodule : tb_extra_irq_select
